//--- src/disp_ctrl_pkg.sv
/*
 * constants, control word layouts and lookup functions for the serial
 * display control block.
 * assumes one core clock; all pins arrive asynchronously.
 */
package disp_ctrl_pkg;

    localparam int SHIFT_W       = 8;
    localparam int WORD_W        = 7;
    localparam int WORD_SEL_BIT  = 7;
    localparam int DOT_BITS      = 160;
    localparam int ROWS          = 8;
    localparam int COLS          = 20;
    localparam int REFRESH_CYC   = 512;
    localparam int REFRESH_W     = 9;
    localparam int ROW_CYC_W     = 6;
    localparam int ROW_ON_MAX    = 60;
    localparam int PRESCALE_DIV  = 8;
    localparam int PRESCALE_W    = 3;
    localparam int SYNC_W        = 6;
    localparam int INT_OSC_HZ    = 200000;
    localparam int CORE_CLK_HZ   = 200000000;
    localparam int INT_OSC_DIV   = CORE_CLK_HZ / INT_OSC_HZ;

    // pin indices inside the synchroniser vector
    localparam int PIN_RS   = 0;
    localparam int PIN_CEN  = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_DIN  = 3;
    localparam int PIN_EOSC = 4;
    localparam int PIN_OSEL = 5;

    typedef struct packed {
        logic       run;        // high = normal, low = sleep
        logic [1:0] peak;       // peak current select
        logic [3:0] pwm;        // on-time code
    } bright_word_s;

    typedef struct packed {
        logic [4:0] zero;       // always written low
        logic       prescale;   // external oscillator divide by eight
        logic       simul;      // pass-through serial out
    } mode_word_s;

    localparam bright_word_s BRIGHT_RST = 7'h00;
    localparam mode_word_s   MODE_RST   = 7'h00;

    function automatic logic [ROW_CYC_W-1:0] pwm_on_cycles(input logic [3:0] code);
        logic [ROW_CYC_W-1:0] t [16];
        t = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
              6'h0B, 6'h0E, 6'h12, 6'h16, 6'h1C, 6'h24, 6'h30, 6'h3C};
        return t[code];
    endfunction

    // relative full-scale current in percent, code is {bit5, bit4}
    function automatic logic [6:0] peak_percent(input logic [1:0] code);
        logic [6:0] p;
        unique case (code)
            2'h2:    p = 7'h1F;
            2'h1:    p = 7'h32;
            2'h0:    p = 7'h49;
            default: p = 7'h64;
        endcase
        return p;
    endfunction

endpackage

//--- src/serial_display_control.sv
/*
 * serial-loaded control logic of a four-character led matrix driver:
 * control and dot shift chains, control words, latch, oscillator
 * selection and row scan with pwm blanking.
 * assumes every pin input is asynchronous to core_clk and that the serial
 * clock is slow enough that each level lasts several core clock cycles.
 */
module serial_display_control
    import disp_ctrl_pkg::*;
#(
    parameter int OSC_DIV = INT_OSC_DIV
) (
    input  wire logic             core_clk,        // 200 MHz core clock
    input  wire logic             sys_rst,         // async reset, active high
    input  wire logic             register_select, // high selects control load
    input  wire logic             chip_enable_n,   // load enable, active low
    input  wire logic             serial_clk,      // serial shift clock
    input  wire logic             serial_din,      // serial data in
    input  wire logic             ext_osc_in,      // external display oscillator
    input  wire logic             ext_osc_sel,     // high uses external oscillator
    input  wire logic             display_off_pin, // high blanks the display
    output logic                  serial_dout,     // serial data out
    output logic                  osc_out,         // display clock for slaves
    output logic [ROWS-1:0]       row_drive,       // one-hot row sink
    output logic [COLS-1:0]       col_drive,       // column current enables
    output logic [6:0]            peak_pct,        // relative peak current
    output logic                  sleeping         // high while in sleep
);

    logic [SYNC_W-1:0]        sync1_q, sync2_q, sync3_q;
    logic [SHIFT_W-1:0]       ctrl_shift_q;
    logic [DOT_BITS-1:0]      dot_shift_q, dot_latch_q;
    bright_word_s             bright_q;
    mode_word_s               mode_q;
    logic                     sel_ctrl_q, pending_q;
    logic [$clog2(OSC_DIV)-1:0] osc_cnt_q;
    logic [PRESCALE_W-1:0]    pre_cnt_q;
    logic [REFRESH_W-1:0]     scan_q;
    logic                     serial_dout_q, osc_out_q, sleeping_q;
    logic [ROWS-1:0]          row_q;
    logic [COLS-1:0]          col_q;
    logic [6:0]               peak_q;
    logic [1:0]               off_sync_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            off_sync_q <= '0;
        end
        else
        begin
            sync1_q <= {ext_osc_sel, ext_osc_in, serial_din, serial_clk,
                        chip_enable_n, register_select};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            off_sync_q <= {off_sync_q[0], display_off_pin};
        end
    end

    wire logic rs_s       = sync2_q[PIN_RS];
    wire logic cen_s      = sync2_q[PIN_CEN];
    wire logic sclk_s     = sync2_q[PIN_SCLK];
    wire logic din_s      = sync2_q[PIN_DIN];
    wire logic sclk_rise  = sclk_s & ~sync3_q[PIN_SCLK];
    wire logic ce_fall    = ~cen_s & sync3_q[PIN_CEN];
    wire logic eosc_rise  = sync2_q[PIN_EOSC] & ~sync3_q[PIN_EOSC];
    wire logic use_ext    = sync2_q[PIN_OSEL];
    wire logic shift_en   = sclk_rise & ~cen_s;
    wire logic commit_ok  = cen_s & ~sclk_s;
    wire logic commit     = commit_ok & pending_q;
    wire logic ctrl_commit = commit & sel_ctrl_q;
    wire logic dot_commit  = commit & ~sel_ctrl_q;
    wire logic word_sel   = ctrl_shift_q[WORD_SEL_BIT];

    // load target is captured as enable falls, shifting marks a pending commit
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sel_ctrl_q <= 1'b0;
            pending_q  <= 1'b0;
        end
        else
        begin
            if (ce_fall)
                sel_ctrl_q <= rs_s;
            if (shift_en)
                pending_q <= 1'b1;
            else if (commit)
                pending_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_shift_q <= '0;
        else if (shift_en && sel_ctrl_q)
            ctrl_shift_q <= {ctrl_shift_q[SHIFT_W-2:0], din_s};
    end

    // dot chain and latch, no reset so leaves them alone
    // sleep never gates shifting or latching
    always_ff @(posedge core_clk)
    begin
        if (shift_en && !sel_ctrl_q)
            dot_shift_q <= {dot_shift_q[DOT_BITS-2:0], din_s};
        if (dot_commit)
            dot_latch_q <= dot_shift_q;
    end

    // words change only on their own commit
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bright_q <= BRIGHT_RST;
            mode_q   <= MODE_RST;
        end
        else if (ctrl_commit)
        begin
            if (word_sel)
                mode_q <= mode_word_s'(ctrl_shift_q[WORD_W-1:0]);
            else
                bright_q <= bright_word_s'(ctrl_shift_q[WORD_W-1:0]);
        end
    end

    // word fields feed pwm, peak, run
    wire logic osc_run   = bright_q.run;
    wire logic int_tick  = osc_run && (osc_cnt_q == ($clog2(OSC_DIV))'(OSC_DIV - 1));
    // prescaler only on the external source
    wire logic ext_tick  = eosc_rise && (!mode_q.prescale ||
                           pre_cnt_q == PRESCALE_W'(PRESCALE_DIV - 1));
    // slaves take the master's clock on the external input
    wire logic disp_tick = use_ext ? ext_tick : int_tick;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            osc_cnt_q <= '0;
            pre_cnt_q <= '0;
        end
        else
        begin
            if (!osc_run || int_tick)
                osc_cnt_q <= '0;
            else
                osc_cnt_q <= osc_cnt_q + 1'b1;
            if (eosc_rise)
                pre_cnt_q <= pre_cnt_q + 1'b1;
        end
    end

    // 512 display clocks per refresh, 64 per row
    wire logic [2:0]           cur_row  = scan_q[REFRESH_W-1:ROW_CYC_W];
    wire logic [ROW_CYC_W-1:0] row_cyc  = scan_q[ROW_CYC_W-1:0];
    wire logic [ROW_CYC_W-1:0] on_time  = pwm_on_cycles(bright_q.pwm);
    wire logic                 lit      = osc_run && !off_sync_q[1] &&
                                          row_cyc < on_time &&
                                          row_cyc < ROW_CYC_W'(ROW_ON_MAX);
    logic [COLS-1:0]           col_d;

    genvar c;
    generate
        for (c = 0; c < COLS; c++)
        begin : g_col
            assign col_d[c] = lit & dot_latch_q[c*ROWS + int'(cur_row)];
        end
    endgenerate

    wire logic dout_d = !sel_ctrl_q ? dot_shift_q[DOT_BITS-1] :
                        mode_q.simul ? din_s : ctrl_shift_q[SHIFT_W-1];

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scan_q        <= '0;
            row_q         <= '0;
            col_q         <= '0;
            serial_dout_q <= 1'b0;
            osc_out_q     <= 1'b0;
            sleeping_q    <= 1'b1;
            peak_q        <= '0;
        end
        else
        begin
            if (disp_tick)
                scan_q <= scan_q + 1'b1;
            if (disp_tick)
                osc_out_q <= ~osc_out_q;
            // blank rows and columns in sleep
            row_q         <= lit ? ROWS'(1) << cur_row : '0;
            col_q         <= col_d;
            serial_dout_q <= dout_d;
            sleeping_q    <= ~osc_run;
            peak_q        <= peak_percent(bright_q.peak);
        end
    end

    assign serial_dout = serial_dout_q;
    assign osc_out     = osc_out_q;
    assign row_drive   = row_q;
    assign col_drive   = col_q;
    assign peak_pct    = peak_q;
    assign sleeping    = sleeping_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_bright_commit;
        ctrl_commit && !word_sel ##1 1'b1;
    endsequence

    commit_window_a: assert property (
        $changed(bright_q) || $changed(mode_q) |-> $past(commit_ok))
        else $error("control word changed outside commit window");
    word_hold_a: assert property (
        !ctrl_commit |=> $stable(bright_q) && $stable(mode_q))
        else $error("control word changed without commit");
    route_mode_a: assert property (
        ctrl_commit && word_sel |=> mode_q == $past(ctrl_shift_q[6:0]) && $stable(bright_q))
        else $error("mode word routing wrong");
    route_bright_a: assert property (
        s_bright_commit |-> bright_q == $past(ctrl_shift_q[6:0]) && $stable(mode_q))
        else $error("brightness word routing wrong");
    sleep_blank_a: assert property (
        !osc_run |=> row_q == '0 && col_q == '0)
        else $error("pixels lit during sleep");
    sleep_osc_a: assert property (
        !osc_run && !use_ext |=> $stable(osc_out_q))
        else $error("internal oscillator ran in sleep");
    shift_move_a: assert property (
        shift_en && sel_ctrl_q |=> ctrl_shift_q[7:1] == $past(ctrl_shift_q[6:0]))
        else $error("control shift did not advance");
    serial_out_a: assert property (
        sel_ctrl_q && !mode_q.simul ##1 $stable(sel_ctrl_q)
        |-> serial_dout_q == $past(ctrl_shift_q[7]))
        else $error("serial out not last shift stage");
    simul_out_a: assert property (
        sel_ctrl_q && mode_q.simul |=> serial_dout_q == $past(din_s))
        else $error("pass-through out does not follow input");
    prescale_a: assert property (
        eosc_rise && use_ext && mode_q.prescale && pre_cnt_q != 3'h7 |-> !disp_tick)
        else $error("prescaler passed an early tick");
    pwm_len_a: assert property (
        row_q != '0 |-> $past(row_cyc) < $past(on_time))
        else $error("row lit past pwm on-time");

endmodule // serial_display_control

//--- tb/host_model.sv
/*
 * host side model: drives the serial load pins of the display control.
 * assumes the bench calls its tasks right after falling core_clk edges.
 */
module host_model (
    input  wire logic core_clk,        // bench clock
    output logic      register_select, // load target
    output logic      chip_enable_n,   // load enable, active low
    output logic      serial_clk,      // shift clock
    output logic      serial_din       // serial data
);
    timeunit 1ns;
    timeprecision 1ps;
    // each serial clock level lasts this many core clocks
    localparam int HALF = 6;
    initial
    begin
        register_select = 1'b0;
        chip_enable_n = 1'b1;
        serial_clk = 1'b0;
        serial_din = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic start(input logic rs);
        register_select = rs;
        idle(HALF);
        chip_enable_n = 1'b0;
        idle(HALF);
    endtask
    // one bit per rising clock, caller sends msb first
    task automatic shift(input logic b);
        serial_clk = 1'b0;
        serial_din = b;
        idle(HALF);
        serial_clk = 1'b1;
        idle(HALF);
    endtask
    // enable rises while the clock is still high
    task automatic raise_ce();
        chip_enable_n = 1'b1;
        serial_din = ~serial_din;
        idle(HALF);
    endtask
    task automatic drop_clk();
        serial_clk = 1'b0;
        idle(HALF);
    endtask
endmodule // host_model

//--- tb/tb.sv
/*
 * self-checking bench for serial_display_control driven by host_model.
 * assumes the internal oscillator divider is shortened to four clocks.
 */
module tb
    import disp_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    typedef struct {
        int          sel;
        logic [31:0] exp;
    } note_s;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_osc_in, ext_osc_sel, display_off_pin, register_select, chip_enable_n;
    logic serial_clk, serial_din, serial_dout, osc_out, sleeping, osc_prev, simul;
    logic [ROWS-1:0]     row_drive;
    logic [COLS-1:0]     col_drive;
    logic [COLS-1:0]     exp_col;
    logic [6:0]          peak_pct, exp_peak;
    logic [DOT_BITS-1:0] dots;
    note_s               notes[$];
    note_s               cur;
    int                  mismatches, tests_run, cmode, cnt;
    logic [6:0]          pk[4] = '{7'h49, 7'h32, 7'h1F, 7'h64};
    int on_t[16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22, 28, 36, 48, 60};
    string what[5] = '{"peak_pct", "sleeping", "serial_dout", "count", "col_drive"};

    always #2.5 core_clk = ~core_clk;

    serial_display_control #(.OSC_DIV(DIV)) dut (.core_clk, .sys_rst, .register_select,
        .chip_enable_n, .serial_clk, .serial_din, .ext_osc_in, .ext_osc_sel,
        .display_off_pin, .serial_dout, .osc_out, .row_drive, .col_drive, .peak_pct,
        .sleeping);
    host_model host (.core_clk, .register_select, .chip_enable_n, .serial_clk, .serial_din);

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic note(input int sel, input logic [31:0] exp);
        notes.push_back('{sel, exp});
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] seen_of(input int sel);
        case (sel)
            0: return 32'(peak_pct);
            1: return 32'(sleeping);
            2: return 32'(serial_dout);
            3: return 32'(cnt);
            default: return 32'(col_drive);
        endcase
    endfunction
    // counts lit cycles or display clock toggles, then settles the notes
    always @(posedge core_clk)
    begin
        // look once the edge's updates have settled
        #1;
        if (cmode == 1 && row_drive != '0) cnt++;
        if (cmode == 2 && osc_out !== osc_prev) cnt++;
        osc_prev = osc_out;
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            check(what[cur.sel], seen_of(cur.sel), cur.exp);
        end
    end
    task automatic do_reset();
        sys_rst = 1'b1;
        idle(15);
        note(0, 0);
        note(1, 1);
        idle(1);
        sys_rst = 1'b0;
        idle(3);
        note(0, 32'h49);
        note(1, 1);
        exp_peak = 7'h49;
        simul = 1'b0;
        $display("reset test done");
    endtask
    task automatic write_word(input logic [7:0] w);
        host.start(1'b1);
        for (int i = 7; i >= 0; i--)
        begin
            host.shift(w[i]);
            if (simul) note(2, w[i]);
        end
        if (!simul) note(2, w[7]);
        host.raise_ce();
        note(0, exp_peak);
        host.drop_clk();
        idle(8);
        if (!w[7]) exp_peak = pk[w[5:4]];
        else simul = w[0];
        note(0, exp_peak);
        if (!w[7]) note(1, !w[6]);
    endtask
    task automatic measure(input int m);
        cnt = 0;
        cmode = m;
        idle(REFRESH_CYC * DIV);
        cmode = 0;
    endtask
    // waits for a fresh row-one lit window; a hang ends the run
    task automatic wait_row1();
        int n;
        n = 0;
        while (row_drive[1] === 1'b1 && n < 4096)
        begin
            idle(1);
            n++;
        end
        while (row_drive[1] !== 1'b1 && n < 4096)
        begin
            idle(1);
            n++;
        end
        if (n >= 4096)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (80000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
    initial
    begin
        {ext_osc_in, ext_osc_sel, display_off_pin, cmode} = '0;
        void'($urandom(32'h0B272F63));
        do_reset();
        for (int i = 0; i < 4; i++) write_word({2'b01, i[1:0], 4'hF});
        $display("peak test done");
        for (int c = 0; c < 16; c++)
        begin
            write_word({2'b01, 2'($urandom), c[3:0]});
            measure(1);
            note(3, ROWS * on_t[c] * DIV);
        end
        $display("pwm test done");
        ext_osc_sel = 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            write_word({1'b1, 5'h00, p[0], 1'b1});
            cnt = 0;
            cmode = 2;
            repeat (64)
            begin
                ext_osc_in = 1'b1;
                idle(4);
                ext_osc_in = 1'b0;
                idle(4);
            end
            idle(20);
            cmode = 0;
            note(3, p ? 8 : 64);
        end
        ext_osc_sel = 1'b0;
        $display("prescale test done");
        dots = {$urandom, $urandom, $urandom, $urandom, $urandom};
        host.start(1'b0);
        for (int i = DOT_BITS - 1; i >= 0; i--) host.shift(dots[i]);
        note(2, dots[DOT_BITS-1]);
        host.raise_ce();
        host.drop_clk();
        write_word(8'h2F);
        measure(1);
        note(3, 0);
        write_word(8'h4F);
        display_off_pin = 1'b1;
        idle(4);
        measure(1);
        note(3, 0);
        display_off_pin = 1'b0;
        idle(4);
        wait_row1();
        for (int c = 0; c < COLS; c++) exp_col[c] = dots[c*ROWS + 1];
        note(4, 32'(exp_col));
        host.start(1'b0);
        note(2, dots[DOT_BITS-1]);
        host.shift(1'b0);
        note(2, dots[DOT_BITS-2]);
        host.raise_ce();
        host.drop_clk();
        $display("sleep and dot test done");
        do_reset();
        note(2, dots[DOT_BITS-2]);
        idle(2);
        complete_run();
    end
endmodule // tb
